// >>> bench/omc_host.sv
// Host model that reaches the register bank through its byte access port.
// Assumes the bench calls wr and rd; signals change at the falling edge.
`timescale 1ns/1ps
module omc_host (
   input  wire logic       SYS_CLK,   // System clock
   output logic      [7:0] REG_ADDR,  // Register address
   output logic      [7:0] REG_WDATA, // Write data
   output logic            REG_WR,    // Write strobe
   output logic            REG_RD,    // Read strobe
   input  wire logic [7:0] REG_RDATA  // Read data
);
   initial begin
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == 8'h16) ? 8'h0F : ((a == 8'h18) ? 8'h03 : 8'hFF);
      @(negedge SYS_CLK);
      REG_ADDR = a;
      REG_WDATA = d & m;
      REG_WR = 1'b1;
      @(negedge SYS_CLK);
      REG_WR = 1'b0;
      REG_WDATA = ~(d & m);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge SYS_CLK);
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(negedge SYS_CLK);
      REG_RD = 1'b0;
      d = REG_RDATA;
   endtask : rd
endmodule : omc_host

// >>> bench/optical_meas_control_regs_tb.sv
// Self-checking bench for the optical measurement control registers.
// Assumes the host model drives the register port and the bench the events.
`timescale 1ns/1ps
module optical_meas_control_regs_tb;
   logic SYS_CLK = 1'b0, RESETN = 1'b0, irq = 1'b0, done = 1'b0, srd = 1'b0, swap = 1'b0;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, active, on, l1, l2, slot;
   logic [1:0] mode;
   logic [9:0] cur, code;
   logic [15:0] lfsr = 16'hAABE;
   int fail_count = 0;
   int n_compared = 0;
   always #20 SYS_CLK = ~SYS_CLK;
   omc_host omc_host_i (.SYS_CLK(SYS_CLK), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
   omc_regs omc_regs_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .PROX_IRQ_SET(irq), .MEAS_DONE(done), .STATUS1_RD(srd), .MEAS_ACTIVE(active),
      .MEAS_MODE(mode), .LED_CURRENT(cur), .LED_ON(on), .LED1_SEL(l1),
      .LED2_SEL(l2), .SLOT_SECOND(slot), .LED_SWAP(swap));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   // Expected {second LED, first LED} selection
   function automatic logic [1:0] exp_sel(input logic [1:0] m, input logic sw, input logic ph);
      case (m)
         2'h0: exp_sel = 2'h1;
         2'h1: exp_sel = sw ? 2'h2 : 2'h1;
         2'h2: exp_sel = (sw ^ ph) ? 2'h2 : 2'h1;
         default: exp_sel = 2'h0;
      endcase
   endfunction : exp_sel
   task automatic chk_v(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_v
   task automatic chk_b(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_b
   task automatic pulse(ref logic s);
      @(negedge SYS_CLK);
      s = 1'b1;
      @(negedge SYS_CLK);
      s = 1'b0;
   endtask : pulse
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      fail_count++;
      end_sim;
   end
   initial begin
      repeat (4) @(negedge SYS_CLK);
      RESETN = 1'b1;
      chk_v("current", 10'h1FF, cur);
      chk_b("led_on", 1'b1, on);
      chk_b("active", 1'b0, active);
      chk_v("mode", 10'h000, {8'h00, mode});
      omc_host_i.rd(8'h16, d);
      chk_v("ctrl", 10'h000, {2'h0, d});
      omc_host_i.rd(8'h17, d);
      chk_v("low", 10'h0FF, {2'h0, d});
      omc_host_i.rd(8'h18, d);
      chk_v("high", 10'h001, {2'h0, d});
      omc_host_i.rd(8'h20, d);
      chk_v("unmapped", 10'h000, {2'h0, d});
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         code = (i == 0) ? 10'h000 : ((i == 1) ? 10'h3FF : lfsr[9:0]);
         omc_host_i.wr(8'h17, code[7:0]);
         omc_host_i.wr(8'h18, {6'h00, code[9:8]});
         chk_v("current", code, cur);
         chk_b("led_on", code != 10'h000, on);
         omc_host_i.rd(8'h18, d);
         chk_v("high", {8'h00, code[9:8]}, {2'h0, d});
         omc_host_i.rd(8'h17, d);
         chk_v("low", {2'h0, code[7:0]}, {2'h0, d});
      end
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            swap = s[0];
            omc_host_i.wr(8'h16, 8'h00);
            omc_host_i.wr(8'h16, {5'h00, m[1:0], 1'b1});
            @(negedge SYS_CLK);
            chk_b("active", 1'b1, active);
            chk_v("mode", {8'h00, (m == 3) ? 2'h0 : m[1:0]}, {8'h00, mode});
            chk_v("sel", {8'h00, exp_sel(m[1:0], s[0], 1'b0)}, {8'h00, l2, l1});
            chk_b("slot", 1'b0, slot);
            pulse(done);
            @(negedge SYS_CLK);
            chk_v("sel", {8'h00, exp_sel(m[1:0], s[0], 1'b1)}, {8'h00, l2, l1});
            chk_b("slot", m == 2, slot);
            pulse(done);
            @(negedge SYS_CLK);
            chk_v("sel", {8'h00, exp_sel(m[1:0], s[0], 1'b0)}, {8'h00, l2, l1});
            chk_b("slot", 1'b0, slot);
         end
      end
      for (int s = 0; s < 2; s++) begin
         omc_host_i.wr(8'h16, {4'h0, s[0], 3'h1});
         pulse(irq);
         pulse(done);
         pulse(srd);
         @(negedge SYS_CLK);
         chk_b("active", !s[0], active);
         omc_host_i.rd(8'h16, d);
         chk_v("ctrl", {6'h00, s[0], 2'h0, !s[0]}, {2'h0, d});
      end
      // Reset in mid-run with interleave running reloads every default
      omc_host_i.wr(8'h16, 8'h05);
      pulse(done);
      @(negedge SYS_CLK);
      RESETN = 1'b0;
      repeat (2) @(negedge SYS_CLK);
      RESETN = 1'b1;
      chk_v("current", 10'h1FF, cur);
      chk_b("active", 1'b0, active);
      chk_v("sel", 10'h000, {8'h00, l2, l1});
      chk_b("slot", 1'b0, slot);
      omc_host_i.rd(8'h16, d);
      chk_v("ctrl", 10'h000, {2'h0, d});
      end_sim;
   end
endmodule : optical_meas_control_regs_tb

// >>> design/omc_led_sel.sv
// LED selection for the pulse-wave and proximity engine.
// Assumes sample_done pulses once per finished sample from the engine.
`timescale 1ns/1ps
module omc_led_sel (
   input  wire logic       SYS_CLK,     // System clock
   input  wire logic       RESETN,      // Async reset, active low
   input  wire logic       active,      // Measurement enabled
   input  wire logic [1:0] mode,        // Mode code
   input  wire logic       swap,        // LED order swap
   input  wire logic       sample_done, // Sample finished pulse
   output logic            use_led1,    // Drive first LED output
   output logic            use_led2,    // Drive second LED output
   output logic            slot_second  // Current sample is second of pair
);
   logic phase;
   logic next_phase;
   wire  interleave = (mode == omc_pkg::MODE_PULSE2);
   wire  single     = (mode == omc_pkg::MODE_PULSE1);
   wire  prox       = (mode == omc_pkg::MODE_PROX);
   wire  ir_now     = interleave ? (phase == swap) : ~swap;
   wire  en_led     = active & (prox | single | interleave);

   assign next_phase = (!active || !interleave) ? 1'b0 :
                       (sample_done ? ~phase : phase);

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         phase       <= 1'b0;
         use_led1    <= 1'b0;
         use_led2    <= 1'b0;
         slot_second <= 1'b0;
      end else begin
         phase       <= next_phase;
         use_led1    <= en_led & (prox | ir_now);
         use_led2    <= en_led & ~prox & ~ir_now;
         slot_second <= next_phase;
      end
   end

   AST_ALTERNATE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (active && interleave && sample_done) |=> (phase != $past(phase)))
      else $error("Interleave phase did not toggle");
endmodule : omc_led_sel

// >>> design/omc_pkg.sv
// Constants for the optical measurement control register bank.
// Assumes an upstream serial-bus slave presents byte-wide register accesses.
package omc_pkg;
   //----------------------------------------------------------------
   // Register map
   //----------------------------------------------------------------
   localparam logic [7:0] SENSING_CONTROL_ADDR  = 8'h16;
   localparam logic [7:0] LED_CURRENT_LOW_ADDR  = 8'h17;
   localparam logic [7:0] LED_CURRENT_HIGH_ADDR = 8'h18;
   localparam logic [7:0] SENSING_CONTROL_RST   = 8'h00;
   localparam logic [7:0] LED_CURRENT_LOW_RST   = 8'hFF;
   localparam logic [7:0] LED_CURRENT_HIGH_RST  = 8'h01;
   localparam logic [7:0] SENSING_CONTROL_MASK  = 8'h0F;
   localparam logic [7:0] LED_CURRENT_HIGH_MASK = 8'h03;
   //----------------------------------------------------------------
   // Field positions
   //----------------------------------------------------------------
   localparam int ENABLE_BIT   = 0;
   localparam int MODE_LSB     = 1;
   localparam int MODE_MSB     = 2;
   localparam int SLEEP_BIT    = 3;
   localparam int HIGH_LSB     = 0;
   localparam int HIGH_MSB     = 1;
   localparam int CURRENT_W    = 10;
   localparam logic [9:0] CURRENT_OFF = 10'h000;
   //----------------------------------------------------------------
   // Modes
   //----------------------------------------------------------------
   localparam logic [1:0] MODE_PROX     = 2'h0;
   localparam logic [1:0] MODE_PULSE1   = 2'h1;
   localparam logic [1:0] MODE_PULSE2   = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   typedef enum logic [1:0] {OMC_LED_NONE, OMC_LED_IR, OMC_LED_RED} omc_led_t;
endpackage : omc_pkg

// >>> design/omc_regs.sv
// Control register bank for the optical measurement engine.
// Assumes a serial-bus slave provides byte accesses with one-cycle write strobes
// and read strobes; engine events arrive as one-cycle pulses on SYS_CLK.
`timescale 1ns/1ps
module omc_regs (
   input  wire logic       SYS_CLK,       // 25 MHz system clock
   input  wire logic       RESETN,        // Async reset, active low
   input  wire logic [7:0] REG_ADDR,      // Register address
   input  wire logic [7:0] REG_WDATA,     // Write data
   input  wire logic       REG_WR,        // Write strobe, one cycle
   input  wire logic       REG_RD,        // Read strobe, one cycle
   output logic      [7:0] REG_RDATA,     // Read data, registered
   input  wire logic       PROX_IRQ_SET,  // Proximity interrupt status set pulse
   input  wire logic       MEAS_DONE,     // Current measurement finished pulse
   input  wire logic       STATUS1_RD,    // Second status register read pulse
   output logic            MEAS_ACTIVE,   // Measurement enable
   output logic      [1:0] MEAS_MODE,     // Effective mode, reserved reads as proximity
   output logic      [9:0] LED_CURRENT,   // LED drive code
   output logic            LED_ON,        // Nonzero drive code
   output logic            LED1_SEL,      // First LED output selected
   output logic            LED2_SEL,      // Second LED output selected
   output logic            SLOT_SECOND,   // Second slot of interleaved pair
   input  wire logic       LED_SWAP       // LED order swap from config register
);
   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   logic [7:0] sensing_control;
   logic [7:0] led_current_low;
   logic [7:0] led_current_high;
   logic       sleep_pending;
   logic       meas_finished;
   logic [7:0] next_rdata;

   // One register's address match, shared by write and read decode
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      reg_hit = (addr == target);
   endfunction : reg_hit

   wire sel_ctrl = reg_hit(REG_ADDR, omc_pkg::SENSING_CONTROL_ADDR);
   wire sel_low  = reg_hit(REG_ADDR, omc_pkg::LED_CURRENT_LOW_ADDR);
   wire sel_high = reg_hit(REG_ADDR, omc_pkg::LED_CURRENT_HIGH_ADDR);

   wire optical_meas_enable = sensing_control[omc_pkg::ENABLE_BIT];
   wire sleep_after_irq     = sensing_control[omc_pkg::SLEEP_BIT];
   wire [1:0] mode_field    = sensing_control[omc_pkg::MODE_MSB:omc_pkg::MODE_LSB];
   wire [1:0] led_drive_high_bits = led_current_high[omc_pkg::HIGH_MSB:omc_pkg::HIGH_LSB];

   // Sleep arms on interrupt, then waits for measurement end and status read
   wire arm_sleep  = sleep_after_irq & optical_meas_enable & PROX_IRQ_SET;
   wire done_seen  = meas_finished | MEAS_DONE;
   wire auto_clear = sleep_pending & done_seen & STATUS1_RD;
   wire host_ctrl  = REG_WR & sel_ctrl;

   // Upper bits are forced to zero whatever the host writes
   wire [7:0] ctrl_wr   = REG_WDATA & omc_pkg::SENSING_CONTROL_MASK;
   wire [7:0] next_ctrl = host_ctrl ? ctrl_wr :
                          auto_clear ? (sensing_control &
                             ~(8'h01 << omc_pkg::ENABLE_BIT)) : sensing_control;

   assign next_rdata = sel_ctrl ? sensing_control :
                       sel_low  ? led_current_low :
                       sel_high ? led_current_high : 8'h00;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sensing_control  <= omc_pkg::SENSING_CONTROL_RST;
         led_current_low  <= omc_pkg::LED_CURRENT_LOW_RST;
         led_current_high <= omc_pkg::LED_CURRENT_HIGH_RST;
         REG_RDATA        <= 8'h00;
      end else begin
         sensing_control <= next_ctrl;
         if (REG_WR && sel_low) begin
            led_current_low <= REG_WDATA;
         end
         if (REG_WR && sel_high) begin
            led_current_high <= REG_WDATA & omc_pkg::LED_CURRENT_HIGH_MASK;
         end
         if (REG_RD) begin
            REG_RDATA <= next_rdata;
         end
      end
   end

   //----------------------------------------------------------------
   // Sleep-after-interrupt sequencing
   //----------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sleep_pending <= 1'b0;
         meas_finished <= 1'b0;
      end else begin
         // Arm wins over clear so a simultaneous interrupt is not lost
         if (arm_sleep) begin
            sleep_pending <= 1'b1;
         end else if (auto_clear || host_ctrl || !optical_meas_enable) begin
            sleep_pending <= 1'b0;
         end
         if (arm_sleep) begin
            meas_finished <= MEAS_DONE;
         end else if (auto_clear || !sleep_pending) begin
            meas_finished <= 1'b0;
         end else if (MEAS_DONE) begin
            meas_finished <= 1'b1;
         end
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   assign MEAS_ACTIVE = optical_meas_enable;
   assign MEAS_MODE   = (mode_field == omc_pkg::MODE_RESERVED) ?
                        omc_pkg::MODE_PROX : mode_field;
   assign LED_CURRENT = {led_drive_high_bits, led_current_low};
   assign LED_ON      = (LED_CURRENT != omc_pkg::CURRENT_OFF);

   omc_led_sel omc_led_sel_i (
      .SYS_CLK     (SYS_CLK),
      .RESETN      (RESETN),
      .active      (optical_meas_enable & (mode_field != omc_pkg::MODE_RESERVED)),
      .mode        (mode_field),
      .swap        (LED_SWAP),
      .sample_done (MEAS_DONE),
      .use_led1    (LED1_SEL),
      .use_led2    (LED2_SEL),
      .slot_second (SLOT_SECOND)
   );

   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   sequence s_irq_armed;
      sleep_after_irq && optical_meas_enable && PROX_IRQ_SET;
   endsequence

   AST_STAY_ACTIVE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (!sleep_after_irq && optical_meas_enable && PROX_IRQ_SET && !host_ctrl)
      |=> optical_meas_enable)
      else $error("Measurement stopped without sleep bit");
   AST_SLEEP_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (sleep_pending && done_seen && STATUS1_RD && !host_ctrl && !arm_sleep)
      |=> !optical_meas_enable)
      else $error("Enable not cleared after done and status read");
   AST_NO_EARLY_CLEAR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (optical_meas_enable && !auto_clear && !host_ctrl) |=> optical_meas_enable)
      else $error("Enable cleared without cause");
   AST_ARMS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      s_irq_armed |=> sleep_pending)
      else $error("Sleep not armed on interrupt");
   AST_UPPER_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (sensing_control[7:4] == 4'h0) && (led_current_high[7:2] == 6'h00))
      else $error("Reserved bits not zero");
   AST_CURRENT_MAP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (REG_WR && sel_high) |=> (LED_CURRENT[9:8] == $past(REG_WDATA[1:0])))
      else $error("Current high bits mismatch");
   AST_LED_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      LED_ON == !((led_current_low == 8'h00) && (led_current_high[1:0] == 2'h0)))
      else $error("LED on flag wrong");
   AST_RESERVED: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (mode_field == omc_pkg::MODE_RESERVED) |=> (!LED1_SEL && !LED2_SEL))
      else $error("Reserved mode drove an LED");
   AST_SINGLE_LED: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (optical_meas_enable && mode_field == omc_pkg::MODE_PULSE1)
      |=> (LED1_SEL != LED2_SEL))
      else $error("Single mode must drive exactly one LED");

   //----------------------------------------------------------------
   // Checks on sleep disarm, mode report, LED selection and register writes
   //----------------------------------------------------------------
   sequence s_clear_ready;
      sleep_pending && done_seen && STATUS1_RD;
   endsequence

   AST_DISARM: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      s_clear_ready ##0 !arm_sleep
      |=> !sleep_pending)
      else $error("Sleep still armed after clear");
   AST_SLEEP_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      !sleep_after_irq |=> !sleep_pending)
      else $error("Sleep armed with sleep bit clear");
   AST_CTRL_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      host_ctrl
      |=> (MEAS_ACTIVE == $past(REG_WDATA[omc_pkg::ENABLE_BIT])))
      else $error("Enable does not follow host write");
   AST_LOW_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (REG_WR && sel_low)
      |=> (LED_CURRENT[7:0] == $past(REG_WDATA)))
      else $error("Current low bits mismatch");
   AST_MODE_REPORT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      MEAS_MODE != omc_pkg::MODE_RESERVED)
      else $error("Reserved mode reported");
   AST_IDLE_NO_LED: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      !optical_meas_enable
      |=> (!LED1_SEL && !LED2_SEL))
      else $error("LED selected while inactive");
   AST_PROX_LED1: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (optical_meas_enable && mode_field == omc_pkg::MODE_PROX)
      |=> (LED1_SEL && !LED2_SEL))
      else $error("Proximity mode must use first LED");
   AST_SINGLE_SWAP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (optical_meas_enable && mode_field == omc_pkg::MODE_PULSE1)
      |=> (LED2_SEL == $past(LED_SWAP)))
      else $error("Single mode LED does not follow swap");
   // Slot flag equals the phase that picked the LED one edge later
   AST_INTERLEAVE_ORDER: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (optical_meas_enable && mode_field == omc_pkg::MODE_PULSE2)
      |=> (LED1_SEL == ($past(SLOT_SECOND) == $past(LED_SWAP))))
      else $error("Interleave order wrong");
   AST_SLOT_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (mode_field != omc_pkg::MODE_PULSE2) |=> !SLOT_SECOND)
      else $error("Second slot flagged outside interleave");
endmodule : omc_regs
